/* File: verilog/uart_house_pkg.sv */
// Purpose: constants for the uart housekeeping register bank
// Assumes: 32-bit axi4-lite register bus, one register per aligned word
// Notes: offsets are byte addresses
package uart_house_pkg;
    // ==========================================================
    // register offsets
    localparam logic [7:0] OFF_INT_ENABLE = 8'h04;
    localparam logic [7:0] OFF_INT_SOURCE = 8'h08;
    localparam logic [7:0] OFF_FIFO_CTRL = 8'h0c;
    localparam logic [7:0] OFF_LINE_CTRL = 8'h10;
    localparam logic [7:0] OFF_MODEM_CTRL = 8'h14;
    localparam logic [7:0] OFF_LINE_STATUS = 8'h18;
    localparam logic [7:0] OFF_MODEM_STATUS = 8'h1c;
    localparam logic [7:0] OFF_SCRATCH = 8'h20;
    localparam logic [7:0] OFF_EVT_STATUS = 8'h24;
    localparam logic [7:0] OFF_EVT_MASK = 8'h28;
    // ==========================================================
    // reset values
    localparam logic [7:0] RST_INT_SOURCE = 8'h01;
    localparam logic [7:0] RST_LINE_STATUS = 8'h60;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_SCRATCH = 8'h00;
    // modem interrupt code in the source register (bits 3:1 = 000, bit0 = 0)
    localparam logic [7:0] INT_SOURCE_MODEM = 8'h00;
    // ==========================================================
    // modem control bit positions
    localparam int MCR_DTR_BIT = 0;
    localparam int MCR_RTS_BIT = 1;
    // event status bits
    localparam int EVT_MODEM_BIT = 0;
    localparam int EVT_WIDTH = 1;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : uart_house_pkg

/* File: verilog/modem_delta.sv */
// Purpose: change detector for one modem input line
// Assumes: input already synchronous to clk_sys
// Notes: set beats the read clear in the same cycle
`timescale 1ns/10ps
`default_nettype none
module modem_delta (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic lineIn,
    input wire logic clearReq,
    output logic changed
);
    logic prev_q;
    logic changed_q;

    // ==========================================================
    // last seen level, sampled every cycle even during reset so no false change appears
    always_ff @(posedge clk_sys) begin
        prev_q <= lineIn;
    end

    // sticky change flag
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            changed_q <= 1'b0;
        end else if (lineIn != prev_q) begin
            changed_q <= 1'b1; // a fresh edge wins over the read clear
        end else if (clearReq) begin
            changed_q <= 1'b0;
        end
    end

    assign changed = changed_q;
endmodule : modem_delta
`default_nettype wire

/* File: verilog/uart_house_regs.sv */
// Purpose: reset state and housekeeping registers of a fifo uart
// Assumes: modem inputs are synchronous levels, active low on the pins
// Notes: serial, fifo and baud logic live elsewhere; this bank holds state
`timescale 1ns/10ps
`default_nettype none
module uart_house_regs
    import uart_house_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // modem inputs, active low: cts, dsr, ri, dcd
    input wire logic ctsIn_n,
    input wire logic dsrIn_n,
    input wire logic riIn_n,
    input wire logic dcdIn_n,
    // serial side outputs
    output logic txOut,
    output logic rtsOut_n,
    output logic dtrOut_n,
    output logic rx_dma_request_n,
    output logic tx_dma_request_n,
    output logic irq
);
    logic [7:0] interrupt_enable_reg_q;
    logic [7:0] line_control_reg_q;
    logic [7:0] modem_control_reg_q;
    logic [7:0] fifo_control_reg_q;
    logic [7:0] line_status_reg_q;
    logic [7:0] interrupt_source_reg_q;
    logic [7:0] scratch_pad_q;
    logic [EVT_WIDTH-1:0] evtStatus_q;
    logic [EVT_WIDTH-1:0] evtMask_q;
    logic [7:0] modem_status_reg;
    logic [3:0] deltaBits;
    logic [3:0] lineLevels;
    logic riPrev_q;
    logic awHeld_q;
    logic wHeld_q;
    logic [7:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic doWrite;
    logic doRead;
    logic msrRead;
    logic evtRead;
    logic modemEvent;
    logic [31:0] rdMux;
    logic rdHit;
    logic wrHit;

    // ==========================================================
    // modem status: upper nibble follows inputs (true sense)
    assign lineLevels = {~dcdIn_n, ~riIn_n, ~dsrIn_n, ~ctsIn_n};

    // cts, dsr and dcd flag any change
    genvar gi;
    for (gi = 0; gi < 4; gi++) begin : g_delta
        if (gi != 2) begin : g_any
            modem_delta u_delta (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .lineIn(lineLevels[gi]),
                .clearReq(msrRead),
                .changed(deltaBits[gi])
            );
        end
    end

    // ring indicator flags only its trailing edge (ri pin going high)
    logic riChanged_q;
    always_ff @(posedge clk_sys) begin
        riPrev_q <= riIn_n;
        if (sys_rst) begin
            riChanged_q <= 1'b0;
        end else if (riIn_n && !riPrev_q) begin
            riChanged_q <= 1'b1;
        end else if (msrRead) begin
            riChanged_q <= 1'b0;
        end
    end
    assign deltaBits[2] = riChanged_q;

    assign modem_status_reg = {lineLevels, deltaBits};
    assign modemEvent = |deltaBits;

    // ==========================================================
    // axi write channel capture; address and data in either order
    assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end else if (doWrite) begin
                awHeld_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end else if (doWrite) begin
                wHeld_q <= 1'b0;
            end
        end
    end

    // ready only while a slot is free, so payload is never overwritten
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !awHeld_q && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !wHeld_q && !(s_axi_wvalid && s_axi_wready);
        end
    end

    always_comb begin
        wrHit = 1'b1;
        unique case (awAddr_q)
            OFF_INT_ENABLE, OFF_FIFO_CTRL, OFF_LINE_CTRL,
            OFF_MODEM_CTRL, OFF_SCRATCH, OFF_EVT_MASK: wrHit = 1'b1;
            OFF_INT_SOURCE, OFF_LINE_STATUS, OFF_MODEM_STATUS,
            OFF_EVT_STATUS: wrHit = 1'b1; // read-only, write ignored
            default: wrHit = 1'b0;
        endcase
    end

    // write response
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // writable control registers, byte lane 0 carries the data
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            interrupt_enable_reg_q <= RST_ZERO;
            line_control_reg_q <= RST_ZERO;
            modem_control_reg_q <= RST_ZERO;
            fifo_control_reg_q <= RST_ZERO;
            evtMask_q <= '0;
        end else if (doWrite && wStrb_q[0]) begin
            unique case (awAddr_q)
                OFF_INT_ENABLE: interrupt_enable_reg_q <= wData_q[7:0];
                OFF_LINE_CTRL: line_control_reg_q <= wData_q[7:0];
                OFF_MODEM_CTRL: modem_control_reg_q <= wData_q[7:0];
                OFF_FIFO_CTRL: fifo_control_reg_q <= wData_q[7:0];
                OFF_EVT_MASK: evtMask_q <= wData_q[EVT_WIDTH-1:0];
                default: ;
            endcase
        end
    end

    // scratch is isolated: nothing else reads it
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            scratch_pad_q <= RST_SCRATCH;
        end else if (doWrite && wStrb_q[0] && awAddr_q == OFF_SCRATCH) begin
            scratch_pad_q <= wData_q[7:0];
        end
    end

    // ==========================================================
    // status registers; serial engines are absent so line status holds reset, source follows modem events
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            line_status_reg_q <= RST_LINE_STATUS;
            interrupt_source_reg_q <= RST_INT_SOURCE;
        end else begin
            line_status_reg_q <= RST_LINE_STATUS;
            // modem status is the only source here; enable bit 3 gates it
            if (modemEvent && interrupt_enable_reg_q[3]) begin
                interrupt_source_reg_q <= INT_SOURCE_MODEM;
            end else begin
                interrupt_source_reg_q <= RST_INT_SOURCE;
            end
        end
    end

    // ==========================================================
    // read channel
    assign doRead = s_axi_arvalid && s_axi_arready;
    assign msrRead = doRead && s_axi_araddr == OFF_MODEM_STATUS;
    assign evtRead = doRead && s_axi_araddr == OFF_EVT_STATUS;

    always_comb begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b1;
        unique case (s_axi_araddr)
            OFF_INT_ENABLE: rdMux[7:0] = interrupt_enable_reg_q;
            OFF_INT_SOURCE: rdMux[7:0] = interrupt_source_reg_q;
            OFF_FIFO_CTRL: rdMux[7:0] = fifo_control_reg_q;
            OFF_LINE_CTRL: rdMux[7:0] = line_control_reg_q;
            OFF_MODEM_CTRL: rdMux[7:0] = modem_control_reg_q;
            OFF_LINE_STATUS: rdMux[7:0] = line_status_reg_q;
            OFF_MODEM_STATUS: rdMux[7:0] = modem_status_reg;
            OFF_SCRATCH: rdMux[7:0] = scratch_pad_q;
            OFF_EVT_STATUS: rdMux[EVT_WIDTH-1:0] = evtStatus_q;
            OFF_EVT_MASK: rdMux[EVT_WIDTH-1:0] = evtMask_q;
            default: rdHit = 1'b0;
        endcase
    end

    // one read in flight; arready drops while rvalid waits
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (doRead) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdMux;
            s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // ==========================================================
    // sticky event bits; a new event beats the read clear
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            evtStatus_q <= '0;
        end else if (modemEvent) begin
            evtStatus_q[EVT_MODEM_BIT] <= 1'b1;
        end else if (evtRead) begin
            evtStatus_q <= '0;
        end
    end

    // level interrupt from a flop
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(evtStatus_q & evtMask_q);
        end
    end

    // ==========================================================
    // pin outputs; modem controls are inverted onto active-low pins
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            txOut <= 1'b1;
            rtsOut_n <= 1'b1;
            dtrOut_n <= 1'b1;
            rx_dma_request_n <= 1'b1;
            tx_dma_request_n <= 1'b0;
        end else begin
            // break bit forces the line low; otherwise idle mark
            txOut <= ~line_control_reg_q[6];
            rtsOut_n <= ~modem_control_reg_q[MCR_RTS_BIT];
            dtrOut_n <= ~modem_control_reg_q[MCR_DTR_BIT];
            rx_dma_request_n <= 1'b1; // no receive data held here
            tx_dma_request_n <= 1'b0; // transmitter always empty here
        end
    end
endmodule : uart_house_regs
`default_nettype wire

/* File: verification/uart_house_assertions.sv */
// Purpose: checker for the uart housekeeping bank
// Assumes: bound to the top module, sees its ports only
// Notes: a single clock domain, so default clocking and disable
`timescale 1ns/10ps
`default_nettype none
module uart_house_assertions
    import uart_house_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ctsIn_n,
    input wire logic dsrIn_n,
    input wire logic riIn_n,
    input wire logic dcdIn_n,
    input wire logic txOut,
    input wire logic rtsOut_n,
    input wire logic dtrOut_n,
    input wire logic rx_dma_request_n,
    input wire logic tx_dma_request_n,
    input wire logic irq
);
    // ==========
    // handshakes and pin levels
    wire logic [3:0] pinLevels = {dcdIn_n, riIn_n, dsrIn_n, ctsIn_n};
    wire logic arTake = s_axi_arvalid && s_axi_arready;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence awTake; s_axi_awvalid && s_axi_awready; endsequence
    sequence wTake; s_axi_wvalid && s_axi_wready; endsequence
    reset_pins_a: assert property ($fell(sys_rst) |->
        txOut && rtsOut_n && dtrOut_n && !irq)
        else $error("pins off after reset");
    dma_levels_a: assert property (
        rx_dma_request_n && !tx_dma_request_n)
        else $error("dma request levels wrong");
    read_answer_a: assert property (arTake |=> s_axi_rvalid)
        else $error("read not answered");
    read_done_a: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    write_answer_a: assert property (
        awTake and wTake |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    status_const_a: assert property (
        arTake && s_axi_araddr == OFF_LINE_STATUS
        |=> s_axi_rdata == {24'h0, RST_LINE_STATUS})
        else $error("line status wrong");
    source_code_a: assert property (
        arTake && s_axi_araddr == OFF_INT_SOURCE
        |=> s_axi_rdata[31:1] == 31'h0)
        else $error("source code wrong");
    modem_level_a: assert property (
        arTake && s_axi_araddr == OFF_MODEM_STATUS
        |=> s_axi_rdata[7:4] == ~$past(pinLevels))
        else $error("modem levels wrong");
endmodule : uart_house_assertions
`default_nettype wire

/* File: verification/host_bus_model.sv */
// Purpose: axi4-lite host that reaches the housekeeping registers
// Assumes: one write and one read at most under way
// Notes: read data is judged by the bench monitor, not here
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
    input wire logic clk_sys,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    // idle bus at time zero
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
    end
    // offer address and data together, drop each once taken
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'h1;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
                break;
        end
        s_axi_bready <= 1'b0;
    endtask : axiWrite
    // rready held up until the answer, so no answer is missed
    task automatic axiRead(input logic [7:0] a);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
                break;
        end
        s_axi_rready <= 1'b0;
    endtask : axiRead
endmodule : host_bus_model
`default_nettype wire

/* File: verification/uart_house_regs_tb_top.sv */
// Purpose: self-checking bench for the uart housekeeping bank
// Assumes: host model drives the bus; bench drives reset and modem pins
// Notes: read results are compared by a monitor against a queue of notes
`timescale 1ns/10ps
`default_nettype none
module uart_house_regs_tb_top
    import uart_house_pkg::*;
;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] pins = 4'hf; // dcd ri dsr cts, idle high
    wire logic [7:0] s_axi_awaddr, s_axi_araddr;
    wire logic [31:0] s_axi_wdata, s_axi_rdata;
    wire logic [3:0] s_axi_wstrb;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    wire logic s_axi_rvalid, s_axi_rready, ctsIn_n, dsrIn_n, riIn_n, dcdIn_n;
    wire logic txOut, rtsOut_n, dtrOut_n, irq;
    wire logic rx_dma_request_n, tx_dma_request_n;
    logic [33:0] expQ[$];
    logic [1:0] respQ[$];
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    assign {dcdIn_n, riIn_n, dsrIn_n, ctsIn_n} = pins;
    uart_house_regs i_uart_house_regs (
        .clk_sys(clk_sys), .sys_rst(sys_rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .ctsIn_n(ctsIn_n), .dsrIn_n(dsrIn_n),
        .riIn_n(riIn_n), .dcdIn_n(dcdIn_n),
        .txOut(txOut), .rtsOut_n(rtsOut_n), .dtrOut_n(dtrOut_n),
        .rx_dma_request_n(rx_dma_request_n),
        .tx_dma_request_n(tx_dma_request_n), .irq(irq)
    );
    host_bus_model host (
        .clk_sys(clk_sys),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );
    // ==========
    // clock, compare and closing
    initial forever #2 clk_sys = ~clk_sys;
    task automatic check(input logic [33:0] g, input logic [33:0] e);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check
    `define CHK(g, e) check(34'(g), 34'(e))
    task automatic test_done();
        $display("checks %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    // a hang is cut short well beyond the few hundred cycles needed
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            test_done();
        end
    end
    // monitor: each read or write answer takes the oldest note
    always @(posedge clk_sys) begin
        if (s_axi_rvalid && s_axi_rready)
            `CHK({s_axi_rresp, s_axi_rdata}, expQ.pop_front());
        if (s_axi_bvalid && s_axi_bready)
            `CHK(s_axi_bresp, respQ.pop_front());
    end
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
            input logic [1:0] r = RESP_OKAY);
        expQ.push_back({r, e});
        host.axiRead(a);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] r = RESP_OKAY);
        respQ.push_back(r);
        host.axiWrite(a, d);
    endtask : wr
    // reset, then reset values at the ports and every register except scratch, event status and event mask
    task automatic doReset();
        sys_rst <= 1'b1;
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        `CHK({txOut, rtsOut_n, dtrOut_n, rx_dma_request_n}, 4'hf);
        `CHK({tx_dma_request_n, irq}, 2'h0);
        rd(OFF_INT_ENABLE, 32'h0);
        rd(OFF_LINE_CTRL, 32'h0);
        rd(OFF_MODEM_CTRL, 32'h0);
        rd(OFF_FIFO_CTRL, 32'h0);
        rd(OFF_INT_SOURCE, {24'h0, RST_INT_SOURCE});
        rd(OFF_LINE_STATUS, {24'h0, RST_LINE_STATUS});
        rd(OFF_MODEM_STATUS, {24'h0, ~pins, 4'h0});
    endtask : doReset
    initial begin
        int b;
        logic hit;
        logic [31:0] w;
        void'($urandom(49));
        doReset();
        $display("test reset done");
        // scratch: random words, only the low byte is kept
        for (int i = 0; i < 4; i++) begin
            w = $urandom;
            wr(OFF_SCRATCH, w);
            rd(OFF_SCRATCH, {24'h0, w[7:0]});
        end
        // a read-only write is ignored, an unmapped one refused
        wr(OFF_LINE_STATUS, 32'h0);
        wr(8'h00, 32'h5a, RESP_SLVERR);
        rd(OFF_MODEM_CTRL, 32'h0);
        rd(OFF_LINE_STATUS, {24'h0, RST_LINE_STATUS});
        rd(OFF_SCRATCH, {24'h0, w[7:0]});
        rd(8'h00, 32'h0, RESP_SLVERR);
        `CHK(irq, 1'b0);
        $display("test scratch done");
        // each modem line falls then rises; ring counts only the rise
        wr(OFF_EVT_MASK, 32'h1);
        wr(OFF_INT_ENABLE, 32'h8);
        for (int i = 0; i < 8; i++) begin
            b = i / 2;
            hit = (b != 2) || (i % 2 == 1);
            @(posedge clk_sys);
            pins[b] <= ~pins[b];
            repeat (4) @(posedge clk_sys);
            #1;
            `CHK(irq, hit);
            rd(OFF_INT_SOURCE, {31'h0, !hit});
            rd(OFF_MODEM_STATUS, {24'h0, ~pins, 4'(hit) << b});
            rd(OFF_MODEM_STATUS, {24'h0, ~pins, 4'h0});
            rd(OFF_EVT_STATUS, {31'h0, hit});
            repeat (3) @(posedge clk_sys);
            #1;
            `CHK(irq, 1'b0);
        end
        $display("test modem done");
        // drive outputs and every control away from reset, then reset
        wr(OFF_MODEM_CTRL, 32'h3);
        wr(OFF_LINE_CTRL, 32'h40);
        wr(OFF_FIFO_CTRL, 32'hc1);
        rd(OFF_FIFO_CTRL, 32'hc1);
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK({txOut, rtsOut_n, dtrOut_n}, 3'h0);
        @(posedge clk_sys);
        pins <= 4'($urandom);
        doReset();
        $display("test second reset done");
        test_done();
    end
endmodule : uart_house_regs_tb_top
bind uart_house_regs uart_house_assertions i_uart_house_assertions (
    .clk_sys(clk_sys), .sys_rst(sys_rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .ctsIn_n(ctsIn_n), .dsrIn_n(dsrIn_n),
    .riIn_n(riIn_n), .dcdIn_n(dcdIn_n),
    .txOut(txOut), .rtsOut_n(rtsOut_n), .dtrOut_n(dtrOut_n),
    .rx_dma_request_n(rx_dma_request_n),
    .tx_dma_request_n(tx_dma_request_n), .irq(irq)
);
`default_nettype wire
